/* File: hw/gpcb_bank.sv */
// GPIO pin configuration bank for pins 1.5 to 2.5 with pad steering and edge interrupts
//
// Notes on behaviour
// R1 - Config bit 0 sets direction: one is input, zero is output.
// R2 - Config bit 1 inverts the pin's logical sense when set.
// R3 - Config bit 7 selects open-drain when set, push-pull when clear.
// R4 - Pins 1.5, 1.6, 1.7 bit 2 route to joystick axis inputs.
// R5 - Pin 2.0 bit 2 connects to keyboard controller port bit 7.
// R6 - Pin 2.1 bits 3:2: floppy select, edge interrupt 0, kbc bit 6, GPIO.
// R7 - Pin 2.2 bits 3:2: motor select, edge interrupt 1, kbc bit 2, GPIO.
// R8 - Edge interrupt mode fires on both rising and falling pin edges.
// R9 - Pin 2.4 has no alternate function; only direction, polarity, type.
// R10 - Pin 2.5 bit 2 routes the pin to the music serial input.
// R11 - Offset 2E is reserved, read-only, and always reads zero.
// R12 - Every pin configuration register resets to 0x01.
// R13 - Reserved bits ignore writes and read back zero.
`timescale 1ns/10ps
`default_nettype none
module gpcb_bank
    import gpcb_pkg::*;
(
    // Clock and standby-power reset
    input  wire logic          clk,
    input  wire logic          arst_n,
    // Register port
    input  wire gpcb_req_s     req,
    output var  logic [7:0]    rdata,
    // Pads
    input  wire logic [NUM_PINS-1:0] padIn,
    output var  gpcb_pad_s     pad,
    // GPIO data side
    input  wire logic [NUM_PINS-1:0] gpioOut,
    output var  logic [NUM_PINS-1:0] gpioIn,
    // Alternate-function side
    input  wire gpcb_alt_out_s altOut,
    output var  gpcb_alt_in_s  altIn,
    // Interrupt
    output var  logic          irq
);

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    function automatic int pinIndex(input logic [7:0] a);
        unique case (a)
            OFF_PIN1_5: pinIndex = P15;
            OFF_PIN1_6: pinIndex = P1_6;
            OFF_PIN1_7: pinIndex = P1_7;
            OFF_PIN2_0: pinIndex = P20;
            OFF_PIN2_1: pinIndex = P21;
            OFF_PIN2_2: pinIndex = P22;
            OFF_PIN2_4: pinIndex = P24;
            OFF_PIN2_5: pinIndex = P25;
            default:    pinIndex = -1;
        endcase
    endfunction : pinIndex

    function automatic logic [7:0] writeMask(input int idx);
        if (idx == P21 || idx == P22) begin
            writeMask = WMASK_ALT2;
        end else if (idx == P24) begin
            writeMask = WMASK_NOALT;  // R9
        end else begin
            writeMask = WMASK_ALT1;
        end
    endfunction : writeMask

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [7:0] cfg      [NUM_PINS];
    logic [7:0] next_cfg [NUM_PINS];
    int         wrIdx;

    always_comb begin
        wrIdx = pinIndex(req.addr);
        for (int i = 0; i < NUM_PINS; i++) begin
            next_cfg[i] = cfg[i];
            if (req.wr && wrIdx == i) begin
                // Reserved bits are dropped on write  R13
                next_cfg[i] = req.wdata & writeMask(i);  // R9
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                cfg[i] <= CFG_RESET;  // R12
            end
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                cfg[i] <= next_cfg[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Pad input synchroniser
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] padMeta;
    logic [NUM_PINS-1:0] padSync;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            padMeta <= '0;
            padSync <= '0;
        end else begin
            padMeta <= padIn;
            padSync <= padMeta;
        end
    end

    // ------------------------------------------------------------
    // Pin function steering
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] isInput;
    logic [NUM_PINS-1:0] invert;
    logic [NUM_PINS-1:0] openDrain;
    logic [NUM_PINS-1:0] altSel;
    logic [NUM_PINS-1:0] logicIn;
    logic [1:0]          sel21;
    logic [1:0]          sel22;

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : gPin
            assign isInput[g]   = cfg[g][BIT_DIR];     // R1
            assign invert[g]    = cfg[g][BIT_POL];     // R2
            assign openDrain[g] = cfg[g][BIT_ODRAIN];  // R3
            assign altSel[g]    = cfg[g][BIT_ALT];
            assign logicIn[g]   = padSync[g] ^ invert[g];  // R2
        end
    endgenerate

    assign sel21 = cfg[P21][BIT_ALT_HI:BIT_ALT];
    assign sel22 = cfg[P22][BIT_ALT_HI:BIT_ALT];

    // Logical output value per pin, before polarity and driver type
    logic [NUM_PINS-1:0] srcOut;

    always_comb begin
        srcOut = gpioOut;
        if (altSel[P20]) begin
            srcOut[P20] = altOut.kbcPortBit7;  // R5
        end
        unique case (sel21)  // R6
            SEL_GPIO:     srcOut[P21] = gpioOut[P21];
            SEL_KBC:      srcOut[P21] = altOut.kbcPortBit6;
            SEL_EDGE_IRQ: srcOut[P21] = gpioOut[P21];
            SEL_FLOPPY:   srcOut[P21] = altOut.driveSelectOneN;
        endcase
        unique case (sel22)  // R7
            SEL_GPIO:     srcOut[P22] = gpioOut[P22];
            SEL_KBC:      srcOut[P22] = altOut.kbcPortBit2;
            SEL_EDGE_IRQ: srcOut[P22] = gpioOut[P22];
            SEL_FLOPPY:   srcOut[P22] = altOut.motorOnOneN;
        endcase
    end

    gpcb_pad_s           next_pad;
    logic [NUM_PINS-1:0] next_gpioIn;
    gpcb_alt_in_s        next_altIn;

    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            // Open drain only ever pulls low; a high releases the pad  R3
            next_pad.out[i] = openDrain[i] ? 1'b0 : (srcOut[i] ^ invert[i]);
            next_pad.oe[i]  = !isInput[i] &&
                              (!openDrain[i] || !(srcOut[i] ^ invert[i]));  // R1
        end
        // GPIO data readback sees the pad regardless of function
        next_gpioIn = logicIn;
        // Peripherals see an idle high when their pin is not selected
        next_altIn.stickAYAxis   = altSel[P15] ? logicIn[P15] : 1'b1;  // R4
        next_altIn.stickBXAxis   = altSel[P1_6] ? logicIn[P1_6] : 1'b1;  // R4
        next_altIn.stickBYAxis   = altSel[P1_7] ? logicIn[P1_7] : 1'b1;  // R4
        next_altIn.kbcPortBit7   = altSel[P20] ? logicIn[P20] : 1'b1;  // R5
        next_altIn.kbcPortBit6   = (sel21 == SEL_KBC) ? logicIn[P21] : 1'b1;  // R6
        next_altIn.kbcPortBit2   = (sel22 == SEL_KBC) ? logicIn[P22] : 1'b1;  // R7
        next_altIn.musicSerialIn = altSel[P25] ? logicIn[P25] : 1'b1;  // R10
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pad    <= '0;
            gpioIn <= '0;
            altIn  <= '1;
        end else begin
            pad    <= next_pad;
            gpioIn <= next_gpioIn;
            altIn  <= next_altIn;
        end
    end

    // ------------------------------------------------------------
    // Either-edge interrupt inputs
    // ------------------------------------------------------------
    logic [NUM_IRQ-1:0] edgeHit;

    gpcb_edge_irq uEdge0 (
        .clk       (clk),
        .arst_n    (arst_n),
        .level     (logicIn[P21]),
        .enable    (sel21 == SEL_EDGE_IRQ),  // R8
        .edgePulse (edgeHit[0])
    );

    gpcb_edge_irq uEdge1 (
        .clk       (clk),
        .arst_n    (arst_n),
        .level     (logicIn[P22]),
        .enable    (sel22 == SEL_EDGE_IRQ),  // R8
        .edgePulse (edgeHit[1])
    );

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    logic [NUM_IRQ-1:0] irqStatus;
    logic [NUM_IRQ-1:0] irqMask;
    logic [NUM_IRQ-1:0] next_irqStatus;
    logic [NUM_IRQ-1:0] next_irqMask;
    logic               next_irq;

    always_comb begin
        next_irqStatus = irqStatus;
        next_irqMask   = irqMask;
        if (req.wr && req.addr == OFF_IRQ_STATUS) begin
            next_irqStatus = irqStatus & ~req.wdata[NUM_IRQ-1:0];
        end
        if (req.wr && req.addr == OFF_IRQ_MASK) begin
            next_irqMask = req.wdata[NUM_IRQ-1:0];
        end
        // A new edge wins over a clear in the same cycle  R8
        next_irqStatus = next_irqStatus | edgeHit;
        next_irq       = |(next_irqStatus & next_irqMask);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irqStatus <= '0;
            irqMask   <= '0;
            irq       <= 1'b0;
        end else begin
            irqStatus <= next_irqStatus;
            irqMask   <= next_irqMask;
            irq       <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------
    logic [7:0] next_rdata;
    int         rdIdx;

    always_comb begin
        rdIdx      = pinIndex(req.addr);
        next_rdata = 8'h00;
        if (req.rd) begin
            if (rdIdx >= 0) begin
                next_rdata = cfg[rdIdx[2:0]];  // R13
            end else if (req.addr == OFF_IRQ_STATUS) begin
                next_rdata = {{(8-NUM_IRQ){1'b0}}, irqStatus};
            end else if (req.addr == OFF_IRQ_MASK) begin
                next_rdata = {{(8-NUM_IRQ){1'b0}}, irqMask};
            end else begin
                // Offset 2E and unmapped addresses read zero  R11
                next_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

endmodule : gpcb_bank
`default_nettype wire

/* File: hw/gpcb_edge_irq.sv */
// Either-edge detector on a synchronised pin level, one per interrupt input
`timescale 1ns/10ps
`default_nettype none
module gpcb_edge_irq
    import gpcb_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Level and enable
    input  wire logic level,
    input  wire logic enable,
    // Event
    output var  logic edgePulse
);

    logic prevLevel;
    logic next_prevLevel;
    logic next_edgePulse;

    always_comb begin
        next_prevLevel = level;
        // Any change counts, rising or falling  R8
        next_edgePulse = enable & (level ^ prevLevel);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prevLevel <= 1'b0;
            edgePulse <= 1'b0;
        end else begin
            prevLevel <= next_prevLevel;
            edgePulse <= next_edgePulse;
        end
    end

endmodule : gpcb_edge_irq
`default_nettype wire

/* File: include/gpcb_pkg.sv */
// Package for the GPIO pin configuration bank: offsets, fields, resets and carriers
package gpcb_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte address on the plain register port)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_PIN1_5     = 8'h28;
    localparam logic [7:0] OFF_PIN1_6     = 8'h29;
    localparam logic [7:0] OFF_PIN1_7     = 8'h2A;
    localparam logic [7:0] OFF_PIN2_0     = 8'h2B;
    localparam logic [7:0] OFF_PIN2_1     = 8'h2C;
    localparam logic [7:0] OFF_PIN2_2     = 8'h2D;
    localparam logic [7:0] OFF_RSVD       = 8'h2E;
    localparam logic [7:0] OFF_PIN2_4     = 8'h2F;
    localparam logic [7:0] OFF_PIN2_5     = 8'h30;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
    localparam logic [7:0] OFF_IRQ_MASK   = 8'h41;

    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam int          NUM_PINS      = 8;
    localparam int          BIT_DIR       = 0;
    localparam int          BIT_POL       = 1;
    localparam int          BIT_ALT       = 2;
    localparam int          BIT_ALT_HI    = 3;
    localparam int          BIT_ODRAIN    = 7;
    localparam logic [7:0]  CFG_RESET     = 8'h01;
    // Writable bits: single-select pins, two-bit-select pins, no-alternate pin
    localparam logic [7:0]  WMASK_ALT1    = 8'h87;
    localparam logic [7:0]  WMASK_ALT2    = 8'h8F;
    localparam logic [7:0]  WMASK_NOALT   = 8'h83;
    localparam logic [1:0]  SEL_GPIO      = 2'h0;
    localparam logic [1:0]  SEL_KBC       = 2'h1;
    localparam logic [1:0]  SEL_EDGE_IRQ  = 2'h2;
    localparam logic [1:0]  SEL_FLOPPY    = 2'h3;
    localparam int          NUM_IRQ       = 2;

    // Pin index within the bank
    localparam int P15 = 0;
    localparam int P1_6 = 1;
    localparam int P1_7 = 2;
    localparam int P20 = 3;
    localparam int P21 = 4;
    localparam int P22 = 5;
    localparam int P24 = 6;
    localparam int P25 = 7;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } gpcb_req_s;

    typedef struct packed {
        logic [NUM_PINS-1:0] out;
        logic [NUM_PINS-1:0] oe;
    } gpcb_pad_s;

    // Alternate-function side: values toward and from on-chip peripherals
    typedef struct packed {
        logic stickAYAxis;
        logic stickBXAxis;
        logic stickBYAxis;
        logic kbcPortBit7;
        logic kbcPortBit6;
        logic kbcPortBit2;
        logic musicSerialIn;
    } gpcb_alt_in_s;

    typedef struct packed {
        logic kbcPortBit7;
        logic kbcPortBit6;
        logic kbcPortBit2;
        logic driveSelectOneN;
        logic motorOnOneN;
    } gpcb_alt_out_s;

endpackage : gpcb_pkg

/* File: tb/gpcb_bank_bench.sv */
// Self-checking bench for the pin configuration bank
`timescale 1ns/10ps
`default_nettype none
module gpcb_bank_bench
    import gpcb_pkg::*;
();
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} gpcb_row_s;
    logic                clk;
    logic                arst_n;
    gpcb_req_s           req;
    logic [7:0]          rdata;
    logic [7:0]          v;
    logic [NUM_PINS-1:0] padIn, gpioOut, gpioIn, extDrv, extEn;
    gpcb_pad_s           pad;
    gpcb_alt_out_s       altOut;
    gpcb_alt_in_s        altIn;
    logic                irq;
    int                  n_mismatch, total_checks;
    // Address, written byte, expected readback
    gpcb_row_s rows [10] = '{
        '{8'h28, 8'hFF, 8'h87}, '{8'h29, 8'hFF, 8'h87}, '{8'h2A, 8'h7A, 8'h02},
        '{8'h2B, 8'hFF, 8'h87}, '{8'h2C, 8'hFF, 8'h8F}, '{8'h2D, 8'h70, 8'h00},
        '{8'h2E, 8'hFF, 8'h00}, '{8'h2F, 8'hFF, 8'h83}, '{8'h30, 8'hFF, 8'h87},
        '{8'h50, 8'hFF, 8'h00}};
    logic [7:0] altAddr [7] = '{8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h30};
    gpcb_bank dut_u (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata), .padIn(padIn),
        .pad(pad), .gpioOut(gpioOut), .gpioIn(gpioIn), .altOut(altOut), .altIn(altIn),
        .irq(irq));
    gpcb_pad_model board_u (.pad(pad), .extDrv(extDrv), .extEn(extEn), .level(padIn));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic pulseReset;
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        for (int a = 8'h28; a <= 8'h30; a++) begin
            rd(8'(a), v);
            chk("reset value", (a == 8'h2E) ? 8'h00 : CFG_RESET, v);
        end
    endtask : pulseReset
    task automatic setAll(input logic [7:0] d);
        foreach (altAddr[i]) wr(altAddr[i], d);
        tick(4);
    endtask : setAll
    task automatic waitIrq;
        // Bounded so a dead interrupt path ends the run instead of hanging
        for (int k = 0; k < 12 && irq !== 1'b1; k++) @(posedge clk);
        #1 chk("irq raised", 8'h01, 8'(irq));
        if (irq !== 1'b1) results();
    endtask : waitIrq
    initial begin
        req = '0;
        gpioOut = '0;
        altOut = '1;
        extDrv = '0;
        extEn = '1;
        n_mismatch = 0;
        total_checks = 0;
        pulseReset();
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            chk("readback", rows[i].e, v);
        end
        $display("test register table done");
        pulseReset();
        wr(OFF_PIN2_4, 8'h02);
        tick(2);
        chk("pad 2.4 push-pull", 8'h03, 8'({pad.oe[P24], pad.out[P24]}));
        tick(3);
        chk("gpioIn 2.4", 8'h00, 8'(gpioIn[P24]));
        wr(OFF_PIN2_4, 8'h82);
        tick(2);
        chk("pad 2.4 drain off", 8'h00, 8'({pad.oe[P24], pad.out[P24]}));
        @(posedge clk);
        gpioOut[P24] <= 1'b1;
        tick(2);
        chk("pad 2.4 drain low", 8'h02, 8'({pad.oe[P24], pad.out[P24]}));
        $display("test pad drive done");
        setAll(8'h05);
        chk("alt in low", 8'h00, 8'(altIn));
        @(posedge clk);
        extDrv <= '1;
        tick(4);
        chk("alt in high", 8'h7F, 8'(altIn));
        setAll(8'h07);
        chk("alt in inverted", 8'h00, 8'(altIn));
        setAll(8'h01);
        chk("alt in idle", 8'h7F, 8'(altIn));
        chk("gpio in", 8'hFF, gpioIn);
        @(posedge clk);
        // Floppy lines high, keyboard lines and GPIO low, so each mux choice shows
        altOut <= gpcb_alt_out_s'(5'b00011);
        wr(OFF_PIN2_1, 8'h0C);
        wr(OFF_PIN2_2, 8'h0C);
        tick(2);
        chk("floppy pads", 8'h0F, 8'({pad.oe[P22:P21], pad.out[P22:P21]}));
        @(posedge clk);
        gpioOut[P22:P21] <= 2'b11;
        wr(OFF_PIN2_1, 8'h04);
        wr(OFF_PIN2_2, 8'h04);
        tick(2);
        chk("kbc pads", 8'h0C, 8'({pad.oe[P22:P21], pad.out[P22:P21]}));
        $display("test alternate functions done");
        @(posedge clk);
        extDrv[P21] <= 1'b0;
        wr(OFF_PIN2_1, 8'h09);
        tick(8);
        wr(OFF_IRQ_MASK, 8'h01);
        wr(OFF_IRQ_STATUS, 8'h03);
        tick(2);
        chk("irq idle", 8'h00, 8'(irq));
        @(posedge clk);
        extDrv[P21] <= 1'b1;
        waitIrq();
        rd(OFF_IRQ_STATUS, v);
        chk("status rise", 8'h01, v);
        wr(OFF_IRQ_STATUS, 8'h01);
        wr(OFF_IRQ_MASK, 8'h00);
        @(posedge clk);
        extDrv[P21] <= 1'b0;
        tick(8);
        chk("irq masked", 8'h00, 8'(irq));
        rd(OFF_IRQ_STATUS, v);
        chk("status fall", 8'h01, v);
        wr(OFF_IRQ_MASK, 8'h01);
        waitIrq();
        wr(OFF_IRQ_STATUS, 8'h01);
        tick(2);
        chk("irq cleared", 8'h00, 8'(irq));
        $display("test interrupt done");
        @(posedge clk);
        req <= '{addr: OFF_PIN1_6, wdata: 8'hFB, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '{addr: OFF_PIN1_6, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 chk("back to back", 8'h83, rdata);
        $display("test back to back done");
        results();
    end
endmodule : gpcb_bank_bench
`default_nettype wire

/* File: tb/gpcb_pad_model.sv */
// Board-side model of the eight pins: design drive, board driver, pull-ups
`timescale 1ns/10ps
`default_nettype none
module gpcb_pad_model
    import gpcb_pkg::*;
(
    // Design side
    input  wire gpcb_pad_s           pad,
    // Board driver set by the bench
    input  wire logic [NUM_PINS-1:0] extDrv,
    input  wire logic [NUM_PINS-1:0] extEn,
    // Resolved pin level
    output var  logic [NUM_PINS-1:0] level
);
    // Released pins take the board driver when extEn is set, else the pull-up, never the last value
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            level[i] = pad.oe[i] ? pad.out[i] : (extEn[i] ? extDrv[i] : 1'b1);
        end
    end
endmodule : gpcb_pad_model
`default_nettype wire

/* File: tb/gpcb_properties.sv */
// Concurrent checks on the ports of the pin configuration bank
`timescale 1ns/10ps
`default_nettype none
module gpcb_properties
    import gpcb_pkg::*;
(
    // Clock and reset
    input wire logic                clk,
    input wire logic                arst_n,
    // Register port, pads, data and alternate sides
    input wire gpcb_req_s           req,
    input wire logic [7:0]          rdata,
    input wire logic [NUM_PINS-1:0] padIn,
    input wire gpcb_pad_s           pad,
    input wire logic [NUM_PINS-1:0] gpioOut,
    input wire logic [NUM_PINS-1:0] gpioIn,
    input wire gpcb_alt_out_s       altOut,
    input wire gpcb_alt_in_s        altIn,
    input wire logic                irq
);
    // ----
    // Shadow configs rebuilt from observed writes
    // ----
    logic [7:0] cfg [NUM_PINS];
    logic [7:0] next_cfg [NUM_PINS];
    logic       msk;
    logic       next_msk;
    logic [7:0] dirV;
    logic [7:0] odV;
    int         idx;
    wire logic  hit = req.addr >= OFF_PIN1_5 && req.addr <= OFF_PIN2_5 && req.addr != OFF_RSVD;
    always_comb begin
        next_cfg = cfg;
        next_msk = msk;
        idx = int'(req.addr) - 40 - int'(req.addr > OFF_RSVD);
        if (req.wr && hit) begin
            next_cfg[idx] = req.wdata & ((idx == P24) ? WMASK_NOALT :
                (idx == P21 || idx == P22) ? WMASK_ALT2 : WMASK_ALT1);
        end
        if (req.wr && req.addr == OFF_IRQ_MASK) begin
            next_msk = req.wdata[0];
        end
        for (int i = 0; i < NUM_PINS; i++) begin
            dirV[i] = cfg[i][BIT_DIR];
            odV[i] = cfg[i][BIT_ODRAIN];
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg <= '{default: CFG_RESET};
            msk <= 1'b0;
        end else begin
            cfg <= next_cfg;
            msk <= next_msk;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_dir_in; (pad.oe & $past(dirV)) == 8'h00; endproperty
    a_dir_in: assert property (p_dir_in) else $error("pad driven while input");
    property p_od_low; (pad.out & $past(odV)) == 8'h00; endproperty
    a_od_low: assert property (p_od_low) else $error("open-drain pad high");
    property p_pp_out; !$past(dirV[P24]) && !$past(odV[P24]) |-> pad.oe[P24] &&
        pad.out[P24] == $past(gpioOut[P24] ^ cfg[P24][BIT_POL]); endproperty
    a_pp_out: assert property (p_pp_out) else $error("pin 2.4 drive wrong");
    property p_stick; altIn.stickAYAxis ==
        ($past(cfg[P15][BIT_ALT]) ? gpioIn[P15] : 1'b1); endproperty
    a_stick: assert property (p_stick) else $error("stick input wrong");
    property p_music; altIn.musicSerialIn ==
        ($past(cfg[P25][BIT_ALT]) ? gpioIn[P25] : 1'b1); endproperty
    a_music: assert property (p_music) else $error("music input wrong");
    property p_edge; $changed(padIn[P21]) && cfg[P21][3:2] == SEL_EDGE_IRQ && msk
        |-> ##[1:8] irq; endproperty
    a_edge: assert property (p_edge) else $error("edge gave no interrupt");
    property p_rsvd; req.rd && req.addr == OFF_RSVD |=> rdata == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved slot not zero");
    property p_rdback; req.rd && hit |=> rdata == $past(cfg[idx]); endproperty
    a_rdback: assert property (p_rdback) else $error("config readback wrong");
    c_irq: cover property ($rose(irq));
    c_rsvd: cover property (req.rd && req.addr == OFF_RSVD);
    c_music: cover property (cfg[P25][BIT_ALT] && !altIn.musicSerialIn);
endmodule : gpcb_properties
bind gpcb_bank gpcb_properties chk_u (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata),
    .padIn(padIn), .pad(pad), .gpioOut(gpioOut), .gpioIn(gpioIn), .altOut(altOut),
    .altIn(altIn), .irq(irq));
`default_nettype wire
